// ---- src/smc_pkg.sv ----
/*
 * Shared constants of the system mode controller: mode-control codes,
 * operating-mode encoding, status word layout and timing counts.
 * Assumes the host divides clk_sys by LINK_DIV to make the link clock.
 */
package smc_pkg;

   // Clock rates
   localparam int CLK_SYS_NS = 10;
   localparam int LINK_DIV   = 4;
   localparam int LINK_NS    = CLK_SYS_NS * LINK_DIV;

   // Mode-control field codes
   localparam logic [3:0] MC_NORMAL  = 4'hf;
   localparam logic [3:0] MC_STANDBY = 4'h6;
   localparam logic [3:0] MC_SLEEP   = 4'h1;
   localparam logic [3:0] MC_LISTEN  = 4'h8;

   // Operating modes of the system mode machine
   typedef enum logic [2:0] {
      SMC_OFF     = 3'h0,
      SMC_BOOT    = 3'h1,
      SMC_CHECK   = 3'h2,
      SMC_STANDBY = 3'h3,
      SMC_SLEEP   = 3'h4,
      SMC_LISTEN  = 3'h5,
      SMC_NORMAL  = 3'h6
   } smc_mode_e;

   // Status word: {hostTimeout, directStart, mode}
   localparam int ST_W           = 5;
   localparam int ST_MODE_LSB    = 0;
   localparam int ST_DIRECT_BIT  = 3;
   localparam int ST_TIMEOUT_BIT = 4;
   localparam logic [ST_W-1:0] ST_RESET = 5'h01;

   // Times in ns and their counts in link clock cycles
   localparam int T_MODE_CH_NS  = 50000;
   localparam int T_SNM_NS      = 100000;
   localparam int T_STARTUP_NS  = 1000000;
   localparam int T_HOST_TO_NS  = 10000000;
   localparam int MODE_CH_CYC   = (T_MODE_CH_NS + LINK_NS - 1) / LINK_NS;
   localparam int SNM_CYC       = (T_SNM_NS + LINK_NS - 1) / LINK_NS;
   localparam int STARTUP_CYC   = T_STARTUP_NS / LINK_NS;
   localparam int HOST_TO_CYC   = (T_HOST_TO_NS + LINK_NS - 1) / LINK_NS;
   localparam int CNT_W         = 20;

endpackage : smc_pkg

// ---- src/smc_link_if.sv ----
/*
 * Link between host and mode controller: link clock, mode commands,
 * transmit data, transmitter disable, receive data and status word.
 * Assumes the host end makes the link clock; no tri-state pins.
 */
`timescale 1ns/1ns
interface smc_link_if;
   logic                      linkClk;
   logic                      cmdStrobe;
   logic [3:0]                cmdMode;
   logic                      cmdReset;
   logic                      txd;
   logic                      txDisableN;
   logic                      rxd;
   logic [smc_pkg::ST_W-1:0]  stWord;
   logic                      stToggle;

   modport dev (
      input  linkClk,
      input  cmdStrobe,
      input  cmdMode,
      input  cmdReset,
      input  txd,
      input  txDisableN,
      output rxd,
      output stWord,
      output stToggle
   );

   modport host (
      output linkClk,
      output cmdStrobe,
      output cmdMode,
      output cmdReset,
      output txd,
      output txDisableN,
      input  rxd,
      input  stWord,
      input  stToggle
   );
endinterface : smc_link_if

// ---- src/smc_device.sv ----
/*
 * Device end: system mode machine of the transceiver, clocked by the
 * link clock. Boots, checks for direct start, follows mode commands,
 * drives the supply switch, receive data and transmit path.
 * Assumes link inputs change away from the rising link clock edge; the
 * side inputs are pins of any timing and pass a three-stage synchroniser.
 */
`timescale 1ns/1ns
// Summary of operation
// R1: Boot clears both flags, the target, busy bit and silence counter
// R2: Boot memory check bounded, branches pass/fail
// R3: Standby keeps supply switch asserted
// R4: Sleep deasserts supply switch
// R5: Code 1111 requests Normal mode
// R6: Code 0110 requests Standby mode
// R7: Code 0001 requests Sleep mode
// R8: Code 1000 requests receive-only mode
// R9: Mode change completes after transition time
// R10: Direct Normal start needs sustained dominant bus
// R11: Recessive bus or command cancels direct start
// R12: Direct start sets direct-start flag
// R13: Flag host timeout on silent pending interrupt
// R14: Reset command forces full system reset
// R15: Reset first, timeout second, others exclusive
// R16: Transmitter off while disable input high
// R17: Pending interrupt drives receive data low in Standby and Sleep
// R18: Undefined mode codes leave mode unchanged
module smc_device #(
   parameter int STARTUP_CYC = smc_pkg::STARTUP_CYC,
   parameter int HOST_TO_CYC = smc_pkg::HOST_TO_CYC
) (
   smc_link_if.dev              link,
   input  wire logic            arst_n,
   input  wire logic            memCheckOk,
   input  wire logic            busDominant,
   input  wire logic            busRx,
   input  wire logic            intPending,
   output logic                 canTx,
   output logic                 supplySwitch,
   output smc_pkg::smc_mode_e   modeState
);

   localparam int W = smc_pkg::CNT_W;
   localparam logic [W-1:0] STARTUP_LIM = W'(STARTUP_CYC - 1);
   localparam logic [W-1:0] HOST_TO_LIM = W'(HOST_TO_CYC);
   localparam logic [W-1:0] SNM_LIM     = W'(smc_pkg::SNM_CYC);
   localparam logic [W-1:0] MOCH_LIM    = W'(smc_pkg::MODE_CH_CYC - 1);
   localparam int           PIN_MEM     = 0;
   localparam int           PIN_DOM     = 1;
   localparam int           PIN_RX      = 2;
   localparam int           PIN_IRQ     = 3;

   typedef struct packed {
      smc_pkg::smc_mode_e         mode;
      smc_pkg::smc_mode_e         tgt;
      logic                       trBusy;
      logic [W-1:0]               cnt;
      logic [W-1:0]               idleCnt;
      logic                       directStart;
      logic                       hostTimeout;
      logic                       spiSeen;
      logic                       busDomPrev;
      logic                       supplySwitch;
      logic                       rxd;
      logic                       canTx;
      logic [smc_pkg::ST_W-1:0]   stWord;
      logic                       stToggle;
      logic [3:0][2:0]            pinSync;
      logic [3:0]                 pinVal;
   } smc_dev_s;

   smc_dev_s q;
   smc_dev_s d;

   smc_pkg::smc_mode_e reqMode;
   logic               reqOk;
   logic               timeoutHit;
   logic               operating;
   logic [3:0]         pinIn;

   assign pinIn = {intPending, busRx, busDominant, memCheckOk};

   // Decode of the mode-control field
   always_comb begin
      reqMode = smc_pkg::SMC_STANDBY;
      reqOk   = 1'b1;
      case (link.cmdMode)
         smc_pkg::MC_NORMAL:  reqMode = smc_pkg::SMC_NORMAL;   // see R5
         smc_pkg::MC_STANDBY: reqMode = smc_pkg::SMC_STANDBY;  // see R6
         smc_pkg::MC_SLEEP:   reqMode = smc_pkg::SMC_SLEEP;    // see R7
         smc_pkg::MC_LISTEN:  reqMode = smc_pkg::SMC_LISTEN;   // see R8
         default:             reqOk   = 1'b0;                  // see R18
      endcase
   end

   always_comb begin
      d = q;
      // Pins come from another domain: a level counts once two stages agree
      for (int i = 0; i < 4; i++) begin
         d.pinSync[i] = {q.pinSync[i][1:0], pinIn[i]};
         if (q.pinSync[i][2] == q.pinSync[i][1]) begin
            d.pinVal[i] = q.pinSync[i][2];
         end
      end
      operating = (q.mode == smc_pkg::SMC_STANDBY) || (q.mode == smc_pkg::SMC_SLEEP) ||
                  (q.mode == smc_pkg::SMC_LISTEN) || (q.mode == smc_pkg::SMC_NORMAL);

      if (link.cmdStrobe) begin
         d.spiSeen = 1'b1;
      end

      // Silence counter runs only while an interrupt waits for the host
      if (link.cmdStrobe || !q.pinVal[PIN_IRQ]) begin
         d.idleCnt = '0;
      end else if (q.idleCnt != HOST_TO_LIM) begin
         d.idleCnt = q.idleCnt + 1'b1;
      end
      timeoutHit = q.pinVal[PIN_IRQ] && !link.cmdStrobe && (q.idleCnt == HOST_TO_LIM) && operating;

      // A command in the same cycle blocks the set, so its clear wins
      if (timeoutHit) begin
         d.hostTimeout = 1'b1;                                  // see R13
      end else if (link.cmdStrobe) begin
         d.hostTimeout = 1'b0;
      end

      if (link.cmdStrobe && link.cmdReset) begin
         // Priority 1: full system reset through boot
         d.mode   = smc_pkg::SMC_BOOT;                          // see R14, R15
         d.trBusy = 1'b0;
         d.cnt    = '0;
      end else if (timeoutHit && !(q.trBusy && q.tgt == smc_pkg::SMC_SLEEP)
                   && q.mode != smc_pkg::SMC_SLEEP) begin
         // Priority 2: host gone quiet, drop to Sleep
         d.tgt    = smc_pkg::SMC_SLEEP;                         // see R15
         d.trBusy = 1'b1;
         d.cnt    = '0;
      end else begin
         case (q.mode)
            smc_pkg::SMC_OFF: begin
               // Failed boot holds here until the next reset
               d.cnt = '0;
            end
            smc_pkg::SMC_BOOT: begin
               d.tgt         = smc_pkg::SMC_BOOT;               // see R1
               d.trBusy      = 1'b0;
               d.directStart = 1'b0;
               d.hostTimeout = 1'b0;
               d.spiSeen     = 1'b0;
               d.idleCnt     = '0;
               d.busDomPrev  = q.pinVal[PIN_DOM];
               d.cnt         = q.cnt + 1'b1;
               if (q.cnt == STARTUP_LIM) begin                  // see R2
                  d.cnt  = '0;
                  d.mode = q.pinVal[PIN_MEM] ? smc_pkg::SMC_CHECK : smc_pkg::SMC_OFF;
               end
            end
            smc_pkg::SMC_CHECK: begin
               if (!q.busDomPrev || !q.pinVal[PIN_DOM] || q.spiSeen || link.cmdStrobe) begin
                  d.mode = smc_pkg::SMC_STANDBY;                // see R11
                  d.cnt  = '0;
               end else if (q.cnt == SNM_LIM) begin
                  d.mode        = smc_pkg::SMC_NORMAL;          // see R10
                  d.directStart = 1'b1;                         // see R12
                  d.cnt         = '0;
               end else begin
                  d.cnt = q.cnt + 1'b1;
               end
            end
            smc_pkg::SMC_STANDBY,
            smc_pkg::SMC_SLEEP,
            smc_pkg::SMC_LISTEN,
            smc_pkg::SMC_NORMAL: begin
               if (link.cmdStrobe && reqOk && (q.trBusy || reqMode != q.mode)) begin
                  // A later command retargets a change already running
                  d.tgt    = reqMode;
                  d.trBusy = 1'b1;
               end
               if (q.trBusy) begin
                  d.cnt = q.cnt + 1'b1;
                  if (q.cnt == MOCH_LIM) begin                  // see R9
                     d.mode   = d.tgt;
                     d.trBusy = 1'b0;
                     d.cnt    = '0;
                  end
               end else begin
                  d.cnt = '0;
               end
            end
            default: begin
               d.mode = smc_pkg::SMC_BOOT;
               d.cnt  = '0;
            end
         endcase
      end

      // Pin levels follow the mode being entered
      d.supplySwitch = (d.mode == smc_pkg::SMC_STANDBY) ||      // see R3
                       (d.mode == smc_pkg::SMC_LISTEN) ||
                       (d.mode == smc_pkg::SMC_NORMAL);         // see R4
      case (d.mode)
         smc_pkg::SMC_SLEEP,
         smc_pkg::SMC_STANDBY: d.rxd = !q.pinVal[PIN_IRQ];      // see R17
         smc_pkg::SMC_LISTEN,
         smc_pkg::SMC_NORMAL:  d.rxd = q.pinVal[PIN_RX];
         default:              d.rxd = 1'b1;
      endcase
      // Recessive unless Normal and the disable input is low
      d.canTx = (d.mode == smc_pkg::SMC_NORMAL && !link.txDisableN) ? link.txd : 1'b1;  // see R16

      d.stWord[smc_pkg::ST_MODE_LSB +: 3]  = d.mode;
      d.stWord[smc_pkg::ST_DIRECT_BIT]     = d.directStart;
      d.stWord[smc_pkg::ST_TIMEOUT_BIT]    = d.hostTimeout;
      // Word and toggle change together; host reads the word after the toggle settles
      if (d.stWord != q.stWord) begin
         d.stToggle = !q.stToggle;
      end
   end

   always_ff @(posedge link.linkClk or negedge arst_n) begin
      if (!arst_n) begin
         q.mode         <= smc_pkg::SMC_BOOT;
         q.tgt          <= smc_pkg::SMC_BOOT;
         q.trBusy       <= 1'b0;
         q.cnt          <= '0;
         q.idleCnt      <= '0;
         q.directStart  <= 1'b0;
         q.hostTimeout  <= 1'b0;
         q.spiSeen      <= 1'b0;
         q.busDomPrev   <= 1'b0;
         q.supplySwitch <= 1'b0;
         q.rxd          <= 1'b1;
         q.canTx        <= 1'b1;
         q.stWord       <= smc_pkg::ST_RESET;
         q.stToggle     <= 1'b0;
         // Stages start at idle pin levels; only receive data idles high
         q.pinSync      <= 12'h1c0;
         q.pinVal       <= 4'h4;
      end else begin
         q <= d;
      end
   end

   assign canTx         = q.canTx;
   assign supplySwitch  = q.supplySwitch;
   assign modeState     = q.mode;
   assign link.rxd      = q.rxd;
   assign link.stWord   = q.stWord;
   assign link.stToggle = q.stToggle;

endmodule : smc_device

// ---- src/smc_host.sv ----
/*
 * Host end: makes the link clock by dividing clk_sys, sends mode and
 * reset commands, drives transmit data and transmitter disable, and
 * brings receive data and the device status back into clk_sys.
 * Assumes the device samples link outputs on the rising link clock.
 */
`timescale 1ns/1ns
module smc_host (
   input  wire logic            clk_sys,
   input  wire logic            arst_n,
   smc_link_if.host             link,
   input  wire logic            reqValid,
   input  wire logic [3:0]      reqMode,
   input  wire logic            reqReset,
   output logic                 reqReady,
   input  wire logic            txData,
   input  wire logic            txOff,
   output logic                 rxData,
   output smc_pkg::smc_mode_e   statusMode,
   output logic                 statusDirect,
   output logic                 statusTimeout
);

   typedef struct packed {
      logic [1:0]  div;
      logic        linkClk;
      logic        cmdStrobe;
      logic [3:0]  cmdMode;
      logic        cmdReset;
      logic        pend;
      logic [3:0]  pMode;
      logic        pReset;
      logic        txd;
      logic        txDisableN;
      logic        reqReady;
      logic [2:0]  tgSync;
      logic        tgSeen;
      logic [2:0]  rxSync;
      logic        rxData;
      logic [smc_pkg::ST_W-1:0] status;
   } smc_host_s;

   smc_host_s q;
   smc_host_s d;

   always_comb begin
      d = q;
      d.div     = q.div + 2'h1;
      d.linkClk = d.div[1];

      if (reqValid && q.reqReady) begin
         d.pend   = 1'b1;
         d.pMode  = reqMode;
         d.pReset = reqReset;
      end

      // Link outputs change only at the falling link edge
      if (q.div == 2'h3) begin
         d.cmdStrobe  = q.pend;
         d.cmdMode    = q.pMode;
         d.cmdReset   = q.pReset;
         d.txd        = txData;
         d.txDisableN = txOff;
         if (q.pend) begin
            d.pend = 1'b0;
         end
      end
      d.reqReady = !d.pend;

      d.tgSync = {q.tgSync[1:0], link.stToggle};
      if (q.tgSync[2] == q.tgSync[1] && q.tgSync[2] != q.tgSeen) begin
         d.tgSeen = q.tgSync[2];
         d.status = link.stWord;
      end
      d.rxSync = {q.rxSync[1:0], link.rxd};
      if (q.rxSync[2] == q.rxSync[1]) begin
         d.rxData = q.rxSync[2];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q.div        <= 2'h0;
         q.linkClk    <= 1'b0;
         q.cmdStrobe  <= 1'b0;
         q.cmdMode    <= 4'h0;
         q.cmdReset   <= 1'b0;
         q.pend       <= 1'b0;
         q.pMode      <= 4'h0;
         q.pReset     <= 1'b0;
         q.txd        <= 1'b1;
         q.txDisableN <= 1'b1;
         q.reqReady   <= 1'b0;
         q.tgSync     <= 3'h0;
         q.tgSeen     <= 1'b0;
         q.rxSync     <= 3'h7;
         q.rxData     <= 1'b1;
         q.status     <= smc_pkg::ST_RESET;
      end else begin
         q <= d;
      end
   end

   assign link.linkClk    = q.linkClk;
   assign link.cmdStrobe  = q.cmdStrobe;
   assign link.cmdMode    = q.cmdMode;
   assign link.cmdReset   = q.cmdReset;
   assign link.txd        = q.txd;
   assign link.txDisableN = q.txDisableN;
   assign reqReady        = q.reqReady;
   assign rxData          = q.rxData;
   assign statusMode      = smc_pkg::smc_mode_e'(q.status[smc_pkg::ST_MODE_LSB +: 3]);
   assign statusDirect    = q.status[smc_pkg::ST_DIRECT_BIT];
   assign statusTimeout   = q.status[smc_pkg::ST_TIMEOUT_BIT];

endmodule : smc_host

// ---- tb/smc_link_assertions.sv ----
/* Concurrent checks on the link between host and mode controller.
   Sees only link signals plus reset; link clock domain only. */
`timescale 1ns/1ns
module smc_link_assertions #(
   parameter int STARTUP_CYC = smc_pkg::STARTUP_CYC
) (
   input wire logic                     linkClk,
   input wire logic                     arst_n,
   input wire logic                     cmdStrobe,
   input wire logic                     cmdReset,
   input wire logic [smc_pkg::ST_W-1:0] stWord,
   input wire logic                     stToggle
);
   localparam int MCH = smc_pkg::MODE_CH_CYC;
   localparam int SNM = smc_pkg::SNM_CYC;
   typedef struct packed {
      logic [19:0] cmdCnt;
      logic [19:0] bootCnt;
      logic [19:0] chkCnt;
      logic        toQ;
      logic        live;
   } smc_chk_s;
   smc_chk_s   st_q;
   smc_chk_s   st_d;
   logic [2:0] mode;
   assign mode = stWord[2:0];
   // Timeout restarts the transition clock one edge late: window of one
   always_comb begin
      st_d         = st_q;
      st_d.toQ     = stWord[4];
      // History is stale or unknown on the first edge after reset
      st_d.live    = 1'b1;
      st_d.cmdCnt  = (cmdStrobe || (stWord[4] && !st_q.toQ)) ? 20'h0 : st_q.cmdCnt + 20'h1;
      st_d.bootCnt = (mode == smc_pkg::SMC_BOOT) ? st_q.bootCnt + 20'h1 : 20'h0;
      st_d.chkCnt  = (mode == smc_pkg::SMC_CHECK) ? st_q.chkCnt + 20'h1 : 20'h0;
   end
   always_ff @(posedge linkClk or negedge arst_n) begin
      if (!arst_n) st_q <= '0;
      else st_q <= st_d;
   end
   default clocking cb @(posedge linkClk); endclocking
   default disable iff (!arst_n);
   chk_strobe_single_cycle: assert property ($rose(cmdStrobe) |=> !cmdStrobe)
      else $error("command strobe longer than one link cycle");
   chk_toggle_pairs_word: assert property (st_q.live |->
      ((stWord != $past(stWord)) == (stToggle != $past(stToggle))))
      else $error("status toggle out of step with status word");
   chk_mode_change_time: assert property ((st_q.live && mode != $past(stWord[2:0])
      && $past(stWord[2:0]) inside {[3'h3:3'h6]} && mode != smc_pkg::SMC_BOOT)
      |-> st_q.cmdCnt inside {[MCH-1:MCH+1]})
      else $error("mode changed outside transition time");
   chk_direct_flag_rise: assert property ((st_q.live && $rose(stWord[3])) |->
      mode == smc_pkg::SMC_NORMAL && $past(stWord[2:0]) == smc_pkg::SMC_CHECK)
      else $error("direct start flag without direct start");
   chk_direct_start_time: assert property ((st_q.live && mode == smc_pkg::SMC_NORMAL
      && $past(stWord[2:0]) == smc_pkg::SMC_CHECK) |-> st_q.chkCnt inside {[SNM:SNM+2]})
      else $error("direct start before check time");
   chk_reset_cmd_boot: assert property (cmdStrobe && cmdReset |-> ##[1:4] mode == smc_pkg::SMC_BOOT)
      else $error("reset command did not restart boot");
   chk_timeout_from_run: assert property ($rose(stWord[4]) |-> $past(stWord[2:0]) inside {[3'h3:3'h6]})
      else $error("host timeout outside running modes");
   chk_boot_length_exit: assert property ((st_q.live && mode != smc_pkg::SMC_BOOT
      && $past(stWord[2:0]) == smc_pkg::SMC_BOOT) |-> st_q.bootCnt inside {[STARTUP_CYC-1:STARTUP_CYC+1]}
      && mode inside {smc_pkg::SMC_OFF, smc_pkg::SMC_CHECK})
      else $error("boot length or exit wrong");
   cov_direct: cover property ($rose(stWord[3]));
   cov_timeout: cover property ($rose(stWord[4]));
   cov_reset_cmd: cover property (cmdStrobe && cmdReset);
endmodule : smc_link_assertions

// ---- tb/test_system_mode_controller.sv ----
/* Bench joining host and device ends over the link interface.
   Assumes only clk_sys from the bench; host makes the link clock. */
`timescale 1ns/1ns
`define CHK(w, e, a) check(w, 8'(e), 8'(a))
module test_system_mode_controller;
   logic               clk_sys     = 1'b0;
   // Starts high so the first reset is a real falling edge for the device
   logic               arst_n      = 1'b1;
   logic               reqValid    = 1'b0;
   logic [3:0]         reqMode     = 4'h0;
   logic               reqReset    = 1'b0;
   logic               txData      = 1'b1;
   logic               txOff       = 1'b1;
   logic               memCheckOk  = 1'b0;
   logic               busDominant = 1'b0;
   logic               busRx       = 1'b1;
   logic               intPending  = 1'b0;
   logic               reqReady;
   logic               rxData;
   logic               statusDirect;
   logic               statusTimeout;
   logic               canTx;
   logic               supplySwitch;
   smc_pkg::smc_mode_e statusMode;
   smc_pkg::smc_mode_e modeState;
   int                 err_total   = 0;
   int                 checked     = 0;
   int                 cycleCount  = 0;
   smc_link_if i_smc_link_if ();
   smc_host i_smc_host (.clk_sys(clk_sys), .arst_n(arst_n), .link(i_smc_link_if.host), .reqValid(reqValid),
      .reqMode(reqMode), .reqReset(reqReset), .reqReady(reqReady), .txData(txData), .txOff(txOff),
      .rxData(rxData), .statusMode(statusMode), .statusDirect(statusDirect), .statusTimeout(statusTimeout));
   smc_device #(.STARTUP_CYC(8), .HOST_TO_CYC(20)) i_smc_device (.link(i_smc_link_if.dev), .arst_n(arst_n),
      .memCheckOk(memCheckOk), .busDominant(busDominant), .busRx(busRx), .intPending(intPending),
      .canTx(canTx), .supplySwitch(supplySwitch), .modeState(modeState));
   smc_link_assertions #(.STARTUP_CYC(8)) i_smc_link_assertions (.linkClk(i_smc_link_if.linkClk),
      .arst_n(arst_n), .cmdStrobe(i_smc_link_if.cmdStrobe), .cmdReset(i_smc_link_if.cmdReset),
      .stWord(i_smc_link_if.stWord), .stToggle(i_smc_link_if.stToggle));
   always #5 clk_sys = ~clk_sys;
   task check(input string w, input logic [7:0] e, input logic [7:0] a);
      checked++;
      if (a !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", w, e, a);
      end
   endtask : check
   task conclude;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   always @(posedge clk_sys) begin
      cycleCount++;
      if (cycleCount == 100000) begin
         err_total++;
         conclude();
      end
   end
   task reset_all;
      arst_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
   endtask : reset_all
   // Values read right after the edge are the settled pre-edge ones
   task send(input logic [3:0] m, input logic r);
      int i;
      // Let the previous take reach reqReady before looking at it
      @(posedge clk_sys);
      for (i = 0; i < 50 && reqReady !== 1'b1; i++) @(posedge clk_sys);
      reqValid <= 1'b1;
      reqMode  <= m;
      reqReset <= r;
      @(posedge clk_sys);
      reqValid <= 1'b0;
   endtask : send
   task wait_mode(input logic [2:0] m, input int lim);
      int i;
      for (i = 0; i < lim && statusMode !== m; i++) @(posedge clk_sys);
   endtask : wait_mode
   task boot_fail;
      reset_all();
      wait_mode(3'h0, 300);
      `CHK("mode after failed check", 3'h0, statusMode);
      `CHK("device mode", 3'h0, modeState);
   endtask : boot_fail
   task direct_start;
      memCheckOk  <= 1'b1;
      busDominant <= 1'b1;
      reset_all();
      @(posedge clk_sys);
      `CHK("status word", 5'h01, i_smc_link_if.stWord);
      wait_mode(3'h6, 20000);
      `CHK("direct start mode", 3'h6, statusMode);
      `CHK("direct start flag", 1'b1, statusDirect);
   endtask : direct_start
   task tx_gate;
      txData <= 1'b0;
      repeat (40) @(posedge clk_sys);
      `CHK("tx disabled", 1'b1, canTx);
      txOff <= 1'b0;
      repeat (40) @(posedge clk_sys);
      `CHK("tx enabled low", 1'b0, canTx);
      txData <= 1'b1;
      repeat (40) @(posedge clk_sys);
      `CHK("tx enabled high", 1'b1, canTx);
      busRx <= 1'b0;
      repeat (40) @(posedge clk_sys);
      `CHK("rx follows bus", 1'b0, rxData);
      busRx <= 1'b1;
   endtask : tx_gate
   task undefined_code;
      send(4'h3, 1'b0);
      repeat (5400) @(posedge clk_sys);
      `CHK("mode after bad code", 3'h6, statusMode);
   endtask : undefined_code
   task mode_codes;
      logic [3:0] code [4] = '{4'h8, 4'h6, 4'h1, 4'hf};
      logic [2:0] want [4] = '{3'h5, 3'h3, 3'h4, 3'h6};
      logic       sup [4]  = '{1'b1, 1'b1, 1'b0, 1'b1};
      logic [2:0] prev;
      int         k;
      for (k = 0; k < 4; k++) begin
         prev = statusMode;
         send(code[k], 1'b0);
         repeat (4900) @(posedge clk_sys);
         `CHK("mode before transition time", prev, statusMode);
         wait_mode(want[k], 600);
         `CHK("commanded mode", want[k], statusMode);
         `CHK("supply switch", sup[k], supplySwitch);
      end
   endtask : mode_codes
   task host_timeout;
      int i;
      intPending <= 1'b1;
      for (i = 0; i < 400 && statusTimeout !== 1'b1; i++) @(posedge clk_sys);
      `CHK("host timeout", 1'b1, statusTimeout);
      wait_mode(3'h4, 5400);
      `CHK("mode after timeout", 3'h4, statusMode);
      repeat (20) @(posedge clk_sys);
      `CHK("rx with pending", 1'b0, rxData);
      `CHK("supply in sleep", 1'b0, supplySwitch);
      intPending <= 1'b0;
   endtask : host_timeout
   task reset_cmd;
      busDominant <= 1'b0;
      send(4'h0, 1'b1);
      wait_mode(3'h1, 100);
      `CHK("mode after reset command", 3'h1, statusMode);
      wait_mode(3'h3, 6000);
      `CHK("mode after recessive check", 3'h3, statusMode);
      `CHK("direct flag", 1'b0, statusDirect);
      `CHK("timeout flag", 1'b0, statusTimeout);
   endtask : reset_cmd
   initial begin
      boot_fail();
      direct_start();
      tx_gate();
      undefined_code();
      mode_codes();
      host_timeout();
      reset_cmd();
      conclude();
   end
endmodule : test_system_mode_controller
